//--- rtl/ssrw_map.svh
// Purpose: Timing counts and reset values for the supply supervisor
// Assumes: 10 MHz core_clk, 100 ns period
// Notes:   Times kept in their own unit, cycle counts derived from them
`ifndef SSRW_MAP_SVH
`define SSRW_MAP_SVH

// ************************************************************
// Timing
// ************************************************************
`define SSRW_CLK_HZ            10000000
`define SSRW_DEBOUNCE_MS       40
`define SSRW_STRETCH_MS        140
`define SSRW_WDOG_MS           1600
`define SSRW_DEBOUNCE_CYC      ((`SSRW_DEBOUNCE_MS * (`SSRW_CLK_HZ / 1000)))
`define SSRW_STRETCH_CYC       ((`SSRW_STRETCH_MS * (`SSRW_CLK_HZ / 1000)))
`define SSRW_WDOG_CYC          ((`SSRW_WDOG_MS * (`SSRW_CLK_HZ / 1000)))

// ************************************************************
// Reset values
// ************************************************************
`define SSRW_RST_BACKUP        1'b1
`define SSRW_RST_HIGH          1'b1
`define SSRW_RST_LOW           1'b0
// Synchroniser reset levels: pushbutton bit idles high
`define SSRW_SYNC_RST          9'h010

`endif

//--- rtl/ssrw_pkg.sv
// Purpose: Types for the supply supervisor
// Assumes: Nothing
// Notes:   Counts live in ssrw_map.svh
package ssrw_pkg;

  typedef enum logic [1:0] {
    SSRW_PB_IDLE    = 2'b00,
    SSRW_PB_QUALIFY = 2'b01,
    SSRW_PB_HELD    = 2'b10
  } ssrw_pb_state_t;

endpackage : ssrw_pkg

//--- rtl/ssrw_supervisor.sv
// Purpose: Reset, watchdog, power-fail and RAM chip-enable supervisor logic
// Assumes: Comparator results arrive digitised and asynchronous to core_clk
// Notes:   Analog switches and comparators stay outside; this block steers them
`timescale 1ns/1ns
`include "ssrw_map.svh"

// What this block does
// - Latch backup request as supply falls through reset threshold; use it below battery
// - Stored backup high: turn battery switch on when supply nears battery
// - Stored backup low: battery switch stays off below battery
// - Floating backup request counts as high
// - Battery-on flag low on supply feed, high on battery with backup high
// - Supply-low flag low below threshold or below battery
// - Pushbutton must stay low 40 ms before reset asserts
// - Pushbutton reset lasts 140 ms after the button is released
// - Power-fail output follows the power-fail comparison
// - Below battery the power-fail output is forced low
// - Kick steady beyond timeout drives reset and watchdog-expired low
// - Floating kick disables the watchdog entirely
// - Every kick transition restarts the watchdog count
// - Watchdog-expired returns high on kick transition or supply-low
// - Chip-enable follows input above threshold, forced high below
// - Reset asserts whenever supply is below threshold or battery
// - Reset holds 140 ms after supply returns above threshold
// - Unserviced watchdog gives a 140 ms reset once per timeout
// - Active-high reset is always the inverse of the active-low reset
// - On battery, ignore backup, pushbutton, kick, power-fail and chip-enable inputs
// - Chip-enable forced high below battery as well
module ssrw_supervisor #(
  parameter int unsigned DEBOUNCE_CYC = `SSRW_DEBOUNCE_CYC,
  parameter int unsigned STRETCH_CYC  = `SSRW_STRETCH_CYC,
  parameter int unsigned WDOG_CYC     = `SSRW_WDOG_CYC,
  parameter int unsigned CNT_W        = 25
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic supply_below_thresh,
  input  wire logic supply_below_batt,
  input  wire logic supply_near_batt,
  input  wire logic pf_cmp_above,
  input  wire logic pushbutton_reset_in_n,
  input  wire logic backup_request,
  input  wire logic backup_request_float,
  input  wire logic watchdog_kick,
  input  wire logic watchdog_kick_float,
  input  wire logic chip_enable_in_n,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      watchdog_expired_n,
  output logic      power_fail_out_n,
  output logic      supply_low_n,
  output logic      battery_on_flag,
  output logic      battery_switch,
  output logic      main_supply_switch,
  output logic      chip_enable_out_n
);

  // ************************************************************
  // Input synchronisers: three stages, change taken when 2 and 3 agree
  // ************************************************************
  localparam int NSYNC = 9;
  // Reset to idle pin levels so no false press follows reset
  localparam logic [NSYNC-1:0] SYNC_RST = `SSRW_SYNC_RST;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [NSYNC-1:0] s3_ff;
  logic [NSYNC-1:0] clean_ff;

  assign raw_in = {supply_below_thresh, supply_below_batt, supply_near_batt,
                   pf_cmp_above, pushbutton_reset_in_n, backup_request,
                   backup_request_float, watchdog_kick, watchdog_kick_float};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_ff[gi]    <= SYNC_RST[gi];
          s2_ff[gi]    <= SYNC_RST[gi];
          s3_ff[gi]    <= SYNC_RST[gi];
          clean_ff[gi] <= SYNC_RST[gi];
        end else begin
          s1_ff[gi] <= raw_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            clean_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  wire below_thr   = clean_ff[8];
  wire below_batt  = clean_ff[7];
  wire near_batt   = clean_ff[6];
  wire pf_above    = clean_ff[5];
  wire pb_n        = clean_ff[4];
  wire bk_req      = clean_ff[3];
  wire bk_float    = clean_ff[2];
  wire kick_lvl    = clean_ff[1];
  wire kick_float  = clean_ff[0];

  // Everything but supply sensing is ignored while on battery
  wire on_batt     = below_batt;
  wire supply_bad  = below_thr | below_batt;

  // ************************************************************
  // Backup mode latch
  // ************************************************************
  logic below_thr_d_ff;
  logic backup_mode_ff;
  wire  bk_level    = bk_req | bk_float;
  wire  thr_fall    = below_thr & ~below_thr_d_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      below_thr_d_ff <= `SSRW_RST_LOW;
      backup_mode_ff <= `SSRW_RST_BACKUP;
    end else begin
      below_thr_d_ff <= below_thr;
      // Capture only on the falling crossing, before battery takeover
      if (thr_fall && !on_batt) begin
        backup_mode_ff <= bk_level;
      end
    end
  end

  // Switch drive: battery switch on only with stored backup high
  wire nxt_batt_sw  = backup_mode_ff & (near_batt | below_batt);
  wire nxt_main_sw  = ~(near_batt | below_batt);
  wire nxt_battery_on_flag  = backup_mode_ff & below_batt;

  // ************************************************************
  // Pushbutton debounce and qualification
  // ************************************************************
  ssrw_pkg::ssrw_pb_state_t pb_state_ff;
  ssrw_pkg::ssrw_pb_state_t nxt_pb_state;
  logic [CNT_W-1:0]         pb_cnt_ff;
  wire  pb_pressed = ~pb_n & ~on_batt;
  wire  pb_done    = (pb_cnt_ff >= CNT_W'(DEBOUNCE_CYC - 1));

  always_comb begin
    nxt_pb_state = pb_state_ff;
    case (pb_state_ff)
      ssrw_pkg::SSRW_PB_IDLE: begin
        if (pb_pressed) begin
          nxt_pb_state = ssrw_pkg::SSRW_PB_QUALIFY;
        end
      end
      ssrw_pkg::SSRW_PB_QUALIFY: begin
        if (!pb_pressed) begin
          nxt_pb_state = ssrw_pkg::SSRW_PB_IDLE;
        end else if (pb_done) begin
          nxt_pb_state = ssrw_pkg::SSRW_PB_HELD;
        end
      end
      ssrw_pkg::SSRW_PB_HELD: begin
        if (!pb_pressed) begin
          nxt_pb_state = ssrw_pkg::SSRW_PB_IDLE;
        end
      end
      default: nxt_pb_state = ssrw_pkg::SSRW_PB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pb_state_ff <= ssrw_pkg::SSRW_PB_IDLE;
      pb_cnt_ff   <= '0;
    end else begin
      pb_state_ff <= nxt_pb_state;
      if (pb_state_ff == ssrw_pkg::SSRW_PB_QUALIFY && pb_pressed) begin
        pb_cnt_ff <= pb_cnt_ff + CNT_W'(1);
      end else begin
        pb_cnt_ff <= '0;
      end
    end
  end

  wire pb_hold = (pb_state_ff == ssrw_pkg::SSRW_PB_HELD);

  // ************************************************************
  // Watchdog
  // ************************************************************
  logic             kick_d_ff;
  logic [CNT_W-1:0] wd_cnt_ff;
  logic             wd_exp_n_ff;
  wire  wd_enable = ~kick_float & ~on_batt;
  wire  kick_edge = (kick_lvl != kick_d_ff) & wd_enable;
  wire  wd_timeout = wd_enable & (wd_cnt_ff >= CNT_W'(WDOG_CYC - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_d_ff <= `SSRW_RST_LOW;
      wd_cnt_ff <= '0;
    end else begin
      kick_d_ff <= kick_lvl;
      // Restart also on each timeout so a stuck kick resets once a period
      if (!wd_enable || kick_edge || wd_timeout || supply_bad) begin
        wd_cnt_ff <= '0;
      end else begin
        wd_cnt_ff <= wd_cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_exp_n_ff <= `SSRW_RST_HIGH;
    end else if (kick_edge || supply_bad || !wd_enable) begin
      wd_exp_n_ff <= `SSRW_RST_HIGH;
    end else if (wd_timeout) begin
      wd_exp_n_ff <= `SSRW_RST_LOW;
    end
  end

  // ************************************************************
  // Reset pulse generator
  // ************************************************************
  logic [CNT_W-1:0] rst_cnt_ff;
  // Any source reloads the stretch; release only after a full quiet stretch
  wire  rst_src    = supply_bad | pb_hold | wd_timeout;
  wire  rst_live   = rst_src | (rst_cnt_ff != '0);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_ff <= CNT_W'(STRETCH_CYC);
    end else begin
      if (rst_src) begin
        rst_cnt_ff <= CNT_W'(STRETCH_CYC);
      end else if (rst_cnt_ff != '0) begin
        rst_cnt_ff <= rst_cnt_ff - CNT_W'(1);
      end
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_out_n        <= `SSRW_RST_LOW;
      reset_out          <= `SSRW_RST_HIGH;
      watchdog_expired_n <= `SSRW_RST_HIGH;
      power_fail_out_n   <= `SSRW_RST_LOW;
      supply_low_n       <= `SSRW_RST_LOW;
      battery_on_flag    <= `SSRW_RST_LOW;
      battery_switch     <= `SSRW_RST_LOW;
      main_supply_switch <= `SSRW_RST_LOW;
      chip_enable_out_n  <= `SSRW_RST_HIGH;
    end else begin
      reset_out_n        <= ~rst_live;
      reset_out          <= rst_live;
      watchdog_expired_n <= wd_exp_n_ff;
      power_fail_out_n   <= pf_above & ~on_batt;
      supply_low_n       <= ~supply_bad;
      battery_on_flag    <= nxt_battery_on_flag;
      battery_switch     <= nxt_batt_sw;
      main_supply_switch <= nxt_main_sw;
      // Chip-enable input is a same-domain gate; delay kept to one cycle
      chip_enable_out_n  <= supply_bad | chip_enable_in_n;
    end
  end

endmodule : ssrw_supervisor

//--- tb/ssrw_checker.sv
// Purpose: Port assertions for the supply supervisor
// Assumes: Counts handed on from the bound instance
// Notes:   Bound to every ssrw_supervisor after endmodule
`timescale 1ns/1ns
module ssrw_checker #(
  parameter int unsigned STRETCH_CYC = 16,
  parameter int unsigned WDOG_CYC    = 64
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic supply_below_thresh,
  input wire logic supply_below_batt,
  input wire logic supply_near_batt,
  input wire logic pf_cmp_above,
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_float,
  input wire logic chip_enable_in_n,
  input wire logic reset_out_n,
  input wire logic reset_out,
  input wire logic watchdog_expired_n,
  input wire logic power_fail_out_n,
  input wire logic supply_low_n,
  input wire logic chip_enable_out_n
);
  logic [15:0] low_ff, idle_ff;
  logic        kick_ff;
  wire         bad  = supply_below_thresh | supply_below_batt;
  wire         good = ~bad & ~supply_near_batt;
  wire         idle_clr = bad | watchdog_kick_float | (watchdog_kick != kick_ff);
  // Pin-side idle count runs ahead of the synced one, so it is a safe lower bound
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_ff  <= 16'h0000;
      idle_ff <= 16'h0000;
      kick_ff <= 1'b0;
    end else begin
      kick_ff <= watchdog_kick;
      low_ff  <= reset_out_n ? 16'h0000 : low_ff + 16'h0001;
      idle_ff <= idle_clr ? 16'h0000 : idle_ff + 16'h0001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  rst_inverse_a: assert property (
    reset_out == ~reset_out_n) else $error("reset pair not inverse");
  ce_follow_a: assert property (
    good [*7] |-> chip_enable_out_n == $past(chip_enable_in_n)) else $error("ce not followed");
  supply_bad_a: assert property (
    bad [*7] |-> !reset_out_n && chip_enable_out_n && !supply_low_n) else $error("bad supply");
  pf_follow_a: assert property (
    (good && $stable(pf_cmp_above)) [*8] |-> power_fail_out_n == pf_cmp_above)
    else $error("pf not followed");
  pf_battery_a: assert property (
    supply_below_batt [*7] |-> !power_fail_out_n) else $error("pf not forced low");
  stretch_min_a: assert property (
    $rose(reset_out_n) |-> low_ff >= STRETCH_CYC) else $error("reset too short");
  wdog_idle_a: assert property (
    $fell(watchdog_expired_n) |-> idle_ff >= WDOG_CYC) else $error("early expiry");
  wdo_clear_a: assert property (
    (watchdog_kick_float || bad) [*7] |-> watchdog_expired_n) else $error("expiry not cleared");
  cover property ($fell(watchdog_expired_n));
  cover property (bad [*7] ##1 good);
  cover property ($rose(reset_out_n));
endmodule : ssrw_checker

bind ssrw_supervisor ssrw_checker #(.STRETCH_CYC(STRETCH_CYC), .WDOG_CYC(WDOG_CYC)) u_checker (
  .core_clk, .reset_n, .supply_below_thresh, .supply_below_batt, .supply_near_batt,
  .pf_cmp_above, .watchdog_kick, .watchdog_kick_float, .chip_enable_in_n, .reset_out_n,
  .reset_out, .watchdog_expired_n, .power_fail_out_n, .supply_low_n, .chip_enable_out_n);

//--- tb/ssrw_cpu_model.sv
// Purpose: Processor side that services the watchdog kick
// Assumes: Toggles only while kick_en is high
// Notes:   Float models the three-level pin left open
`timescale 1ns/1ns
module ssrw_cpu_model #(
  parameter int unsigned KICK_GAP = 20
) (
  input  wire logic core_clk,
  input  wire logic kick_en,
  input  wire logic float_en,
  output logic      watchdog_kick,
  output logic      watchdog_kick_float
);
  logic [7:0] gap_ff  = 8'h00;
  logic       kick_ff = 1'b0;
  wire        due     = (gap_ff == 8'(KICK_GAP));
  always_ff @(posedge core_clk) begin
    gap_ff  <= due ? 8'h00 : gap_ff + 8'h01;
    kick_ff <= kick_ff ^ (kick_en & due);
  end
  assign watchdog_kick       = kick_ff;
  assign watchdog_kick_float = float_en;
endmodule : ssrw_cpu_model

//--- tb/tb.sv
// Purpose: Self-checking bench for the supply supervisor
// Assumes: Short counts DB, ST, WD
// Notes:   Inputs change on the rising edge, outputs read on the falling
`timescale 1ns/1ns
module tb;
  localparam int unsigned DB = 8;
  localparam int unsigned ST = 16;
  localparam int unsigned WD = 64;
  logic core_clk = 1'b0, reset_n = 1'b0, kick_en = 1'b0, float_en = 1'b1;
  logic supply_below_thresh = 1'b0, supply_below_batt = 1'b0, supply_near_batt = 1'b0;
  logic pf_cmp_above = 1'b1, pushbutton_reset_in_n = 1'b1, chip_enable_in_n = 1'b1;
  logic backup_request = 1'b1, backup_request_float = 1'b0, v, w;
  logic watchdog_kick, watchdog_kick_float, reset_out_n, reset_out, watchdog_expired_n;
  logic power_fail_out_n, supply_low_n, battery_on_flag, battery_switch;
  logic main_supply_switch, chip_enable_out_n;
  int   mismatches = 0, samples_checked = 0, cycles = 0, n;

  ssrw_supervisor #(.DEBOUNCE_CYC(DB), .STRETCH_CYC(ST), .WDOG_CYC(WD)) dut (.*);
  ssrw_cpu_model #(.KICK_GAP(20)) partner (.*);

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  task automatic results;
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // Bounded wait on a level, counted in falling edges
  task automatic wait_for(input int sel);
    n = 0;
    while ((sel ? watchdog_expired_n : ~reset_out_n) !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      $display("FAIL %0t wait limit reached", $time);
    end
  endtask : wait_for

  initial begin
    void'($urandom(71));
    @(negedge core_clk);
    chk(reset_out, 1'b1);
    chk(chip_enable_out_n, 1'b1);
    cyc(2);
    reset_n <= 1'b1;
    @(negedge core_clk);
    wait_for(0);
    chk(n >= ST, 1'b1);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      v = 1'($urandom);
      w = 1'($urandom);
      chip_enable_in_n <= v;
      pf_cmp_above     <= w;
      cyc(7);
      @(negedge core_clk);
      chk(chip_enable_out_n, v);
      chk(power_fail_out_n, w);
    end
    // Modes: latched low, latched high, pin left open
    for (int m = 0; m < 3; m++) begin
      cyc(1);
      backup_request       <= 1'(m == 1);
      backup_request_float <= 1'(m == 2);
      pf_cmp_above         <= 1'b1;
      chip_enable_in_n     <= 1'b0;
      cyc(8);
      supply_below_thresh <= 1'b1;
      cyc(8);
      backup_request       <= 1'(m != 1);
      backup_request_float <= 1'b0;
      @(negedge core_clk);
      chk(reset_out_n, 1'b0);
      chk(supply_low_n, 1'b0);
      chk(chip_enable_out_n, 1'b1);
      cyc(1);
      supply_near_batt  <= 1'b1;
      supply_below_batt <= 1'b1;
      cyc(8);
      @(negedge core_clk);
      chk(battery_switch, 1'(m != 0));
      chk(battery_on_flag, 1'(m != 0));
      chk(power_fail_out_n, 1'b0);
      chk(main_supply_switch, 1'b0);
      cyc(1);
      supply_near_batt  <= 1'b0;
      supply_below_batt <= 1'b0;
      cyc(8);
      supply_below_thresh <= 1'b0;
      @(negedge core_clk);
      wait_for(0);
      chk(n >= ST, 1'b1);
      chk(main_supply_switch, 1'b1);
    end
    cyc(1);
    pushbutton_reset_in_n <= 1'b0;
    cyc(DB - 3);
    pushbutton_reset_in_n <= 1'b1;
    cyc(12);
    @(negedge core_clk);
    chk(reset_out_n, 1'b1);
    cyc(1);
    pushbutton_reset_in_n <= 1'b0;
    cyc(DB + 8);
    @(negedge core_clk);
    chk(reset_out_n, 1'b0);
    cyc(1);
    pushbutton_reset_in_n <= 1'b1;
    @(negedge core_clk);
    wait_for(0);
    chk(n >= ST, 1'b1);
    cyc(1);
    float_en <= 1'b0;
    kick_en  <= 1'b1;
    cyc(3 * WD);
    @(negedge core_clk);
    chk(watchdog_expired_n, 1'b1);
    cyc(1);
    kick_en <= 1'b0;
    wait_for(1);
    chk(watchdog_expired_n, 1'b0);
    @(negedge core_clk);
    chk(reset_out_n, 1'b0);
    cyc(1);
    kick_en <= 1'b1;
    cyc(30);
    @(negedge core_clk);
    chk(watchdog_expired_n, 1'b1);
    cyc(1);
    kick_en  <= 1'b0;
    float_en <= 1'b1;
    cyc(3 * WD);
    @(negedge core_clk);
    chk(watchdog_expired_n, 1'b1);
    results();
  end
endmodule : tb
